// ===== hw/pqsc_regs.svh
`ifndef PQSC_REGS_SVH
`define PQSC_REGS_SVH
// Opcodes
`define PQSC_OP_PWR_QUERY 8'hE5
`define PQSC_OP_PWR_QUERY_ALT 8'h98
`define PQSC_OP_STREAM_CFG 8'h51
// Drive/head bits
`define PQSC_DH_LBA_BIT 6
`define PQSC_DH_DEV_BIT 4
`define PQSC_DH_RETRY_BIT 7
// Feature current bits
`define PQSC_FT_ADD_BIT 7
`define PQSC_FT_DIR_BIT 6
`define PQSC_FT_ID_LSB 0
`define PQSC_FT_ID_MSB 2
// Power mode answers
`define PQSC_PM_ACTIVE 8'hFF
`define PQSC_PM_STANDBY 8'h00
`define PQSC_PM_IDLE_A 8'h81
`define PQSC_PM_IDLE_B 8'h82
`define PQSC_PM_IDLE_C 8'h83
`define PQSC_PM_STANDBY_Y 8'h01
`define PQSC_PM_STANDBY_Z 8'h00
// Status and error bit positions
`define PQSC_ST_BUSY 7
`define PQSC_ST_READY 6
`define PQSC_ST_FAULT 5
`define PQSC_ST_SEEK 4
`define PQSC_ST_CORR 2
`define PQSC_ST_ERR 0
`define PQSC_ER_ABORT 2
// Reset values
`define PQSC_STATUS_RST 8'h40
`define PQSC_ERROR_RST 8'h00
// Host register offsets on the Avalon slave (word addresses)
`define PQSC_AV_CTRL 2'h0
`define PQSC_AV_TASK 2'h1
`define PQSC_AV_RESULT 2'h2
`define PQSC_AV_STAT 2'h3
`endif

// ===== hw/pqsc_pkg.sv
package pqsc_pkg;
  // Power condition of the device
  typedef enum logic [2:0] {
    PQSC_PWR_ACTIVE = 3'h0,
    PQSC_PWR_IDLE_A = 3'h1,
    PQSC_PWR_IDLE_B = 3'h2,
    PQSC_PWR_IDLE_C = 3'h3,
    PQSC_PWR_STANDBY_Y = 3'h4,
    PQSC_PWR_STANDBY_Z = 3'h5
  } pqsc_pwr_t;
  // One stored stream
  typedef struct packed {
    logic valid;
    logic write_dir;
    logic [31:0] time_limit;
    logic [15:0] alloc_size;
  } pqsc_stream_t;
endpackage

// ===== hw/pqsc_if.sv
`timescale 1ns/1ps
// Task-file link between host controller and device
interface pqsc_if;
  logic cmd_valid;
  logic [7:0] command;
  logic [7:0] feature_cur;
  logic [7:0] feature_prev;
  logic [7:0] count_cur;
  logic [7:0] count_prev;
  logic [7:0] drive_head;
  logic done_irq;
  logic [7:0] command_status_flags;
  logic [7:0] command_error_flags;
  logic [7:0] count_out;
  modport dev (input cmd_valid, input command, input feature_cur, input feature_prev,
    input count_cur, input count_prev, input drive_head, output done_irq,
    output command_status_flags, output command_error_flags, output count_out);
  modport host (output cmd_valid, output command, output feature_cur, output feature_prev,
    output count_cur, output count_prev, output drive_head, input done_irq,
    input command_status_flags, input command_error_flags, input count_out);
endinterface

// ===== hw/pqsc_device.sv
`timescale 1ns/1ps
`include "pqsc_regs.svh"
module pqsc_device #(
  parameter int STREAMS = 8,
  parameter logic [15:0] TIME_UNIT_US = 16'h000A,
  parameter logic [31:0] MIN_LIMIT_US = 32'h0000_0064
) (
  input wire logic ref_clk,
  input wire logic resetn,
  pqsc_if.dev link,
  input wire logic stream_supported,
  input wire logic ext_power_enable,
  input wire pqsc_pkg::pqsc_pwr_t power_state,
  input wire logic [2:0] query_id,
  input wire logic [31:0] query_limit_us,
  output logic [31:0] applied_limit_us,
  output logic lba_mode,
  output logic [31:0] elapsed_cycles
);
  // ****************************************
  // State
  // ****************************************
  // One packed word holds every register of the device: the stream table,
  // the completion answer on the link and the lookup result. Keeping the
  // table in the same word means a reset forgets every stream at once.
  typedef struct packed {
    pqsc_pkg::pqsc_stream_t [STREAMS-1:0] streams;
    logic done_irq;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] count_out;
    logic [31:0] applied;
    logic lba;
    logic [31:0] elapsed;
  } pqsc_dev_state_t;

  pqsc_dev_state_t st;
  pqsc_dev_state_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  // Default limit from the count of time units. Short requests are raised to
  // the floor, so a stored default is never a limit the device cannot meet; a nonzero requested limit is applied unraised.
  function automatic logic [31:0] pqsc_default_limit(input logic [7:0] units);
    logic [31:0] raw;
    raw = 32'(units) * 32'(TIME_UNIT_US);
    if (raw < MIN_LIMIT_US) begin
      raw = MIN_LIMIT_US;
    end
    return raw;
  endfunction

  // New table entry for an add request
  function automatic pqsc_pkg::pqsc_stream_t pqsc_new_stream(input logic [7:0] feat,
      input logic [31:0] lim,
      input logic [15:0] size);
    pqsc_pkg::pqsc_stream_t s;
    s.valid = 1'b1;
    s.write_dir = feat[`PQSC_FT_DIR_BIT];
    s.time_limit = lim;
    s.alloc_size = size;
    return s;
  endfunction

  // Completion status: busy, fault and corrected are always clear and ready
  // is always set, since the command is fully done when the interrupt rises
  function automatic logic [7:0] pqsc_done_status(input logic abort, input logic known);
    logic [7:0] s;
    s = 8'h00;
    s[`PQSC_ST_READY] = 1'b1;
    s[`PQSC_ST_SEEK] = known && !abort;
    s[`PQSC_ST_ERR] = abort;
    return s;
  endfunction

  // Only the abort bit has a source here; CRC and media bits stay clear
  function automatic logic [7:0] pqsc_done_error(input logic abort);
    logic [7:0] e;
    e = 8'h00;
    e[`PQSC_ER_ABORT] = abort;
    return e;
  endfunction

  // Power condition to answer code
  // With extended conditions off the sub-levels fold into the plain
  // answers: any idle level reads as active, either standby level as zero
  function automatic logic [7:0] pqsc_power_code(input logic extended_power_conditions,
                                                  input pqsc_pkg::pqsc_pwr_t p);
    logic [7:0] code;
    code = `PQSC_PM_ACTIVE;
    if (!extended_power_conditions) begin
      if (p == pqsc_pkg::PQSC_PWR_STANDBY_Y || p == pqsc_pkg::PQSC_PWR_STANDBY_Z) begin
        code = `PQSC_PM_STANDBY;
      end
    end else begin
      case (p)
        pqsc_pkg::PQSC_PWR_IDLE_A: code = `PQSC_PM_IDLE_A;
        pqsc_pkg::PQSC_PWR_IDLE_B: code = `PQSC_PM_IDLE_B;
        pqsc_pkg::PQSC_PWR_IDLE_C: code = `PQSC_PM_IDLE_C;
        pqsc_pkg::PQSC_PWR_STANDBY_Y: code = `PQSC_PM_STANDBY_Y;
        pqsc_pkg::PQSC_PWR_STANDBY_Z: code = `PQSC_PM_STANDBY_Z;
        default: code = `PQSC_PM_ACTIVE;
      endcase
    end
    return code;
  endfunction

  // ****************************************
  // Command decode and completion
  // ****************************************
  always_comb begin
    logic [2:0] id;
    logic add;
    logic abort;
    logic [31:0] lim;
    logic known;
    id = link.feature_cur[`PQSC_FT_ID_MSB:`PQSC_FT_ID_LSB];
    add = link.feature_cur[`PQSC_FT_ADD_BIT];
    abort = 1'b0;
    lim = pqsc_default_limit(link.feature_prev);
    known = 1'b1;
    next_st = st;
    next_st.done_irq = 1'b0;
    // Drive-select and retry bits are never looked at
    if (link.cmd_valid) begin
      next_st.lba = link.drive_head[`PQSC_DH_LBA_BIT];
      // Command taken here and interrupt raised on the next edge: one cycle
      next_st.elapsed = 32'h0000_0001;
      case (link.command)
        `PQSC_OP_PWR_QUERY, `PQSC_OP_PWR_QUERY_ALT: begin
          next_st.count_out = pqsc_power_code(ext_power_enable, power_state);
        end
        `PQSC_OP_STREAM_CFG: begin
          // Abort reasons are settled before anything is stored
          if (!stream_supported) begin
            abort = 1'b1;
          end else if (!add && !st.streams[id].valid) begin
            abort = 1'b1;
          end
          // Store only when not aborted; old entry stays otherwise
          if (!abort) begin
            if (add) begin
              next_st.streams[id] = pqsc_new_stream(link.feature_cur, lim,
                  {link.count_prev, link.count_cur});
            end else begin
              // Removal only drops the valid bit; the stale fields are never read
              next_st.streams[id].valid = 1'b0;
            end
          end
        end
        default: begin
          known = 1'b0;
          abort = 1'b1;
        end
      endcase
      // Status and error change together with the interrupt, never before it
      next_st.done_irq = 1'b1;
      next_st.status = pqsc_done_status(abort, known);
      next_st.error = pqsc_done_error(abort);
    end
    // Zero requested limit falls back to the stored default
    // An unknown or removed stream passes the requested limit straight through
    if (query_limit_us == 32'h0000_0000 && st.streams[query_id].valid) begin
      next_st.applied = st.streams[query_id].time_limit;
    end else begin
      next_st.applied = query_limit_us;
    end
  end

  // ****************************************
  // Register stage
  // ****************************************
  // Single register stage for all state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.status <= `PQSC_STATUS_RST;
      st.error <= `PQSC_ERROR_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a field of the state word, so none has a combinational path
  assign link.done_irq = st.done_irq;
  assign link.command_status_flags = st.status;
  assign link.command_error_flags = st.error;
  assign link.count_out = st.count_out;
  assign applied_limit_us = st.applied;
  assign lba_mode = st.lba;
  assign elapsed_cycles = st.elapsed;
endmodule

// ===== hw/pqsc_host.sv
`timescale 1ns/1ps
`include "pqsc_regs.svh"
// Host controller: Avalon-MM slave issuing task-file commands
module pqsc_host (
  input wire logic ref_clk,
  input wire logic resetn,
  pqsc_if.host link,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] drive_head;
    logic [7:0] feature_cur;
    logic [7:0] feature_prev;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic issue;
    logic pending;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] count_in;
    logic [31:0] rdata;
    logic ack;
  } pqsc_host_state_t;

  pqsc_host_state_t st;
  pqsc_host_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.issue = 1'b0;
    next_st.ack = 1'b0;
    // One wait cycle per access, ack ends it
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack = 1'b1;
      if (avs_write) begin
        case (avs_address)
          `PQSC_AV_CTRL: begin
            if (!st.pending) begin
              next_st.command = avs_writedata[7:0];
              // Retry bit sent as zero, drive bit as zero
              next_st.drive_head = avs_writedata[15:8] & 8'h6F;
              next_st.issue = 1'b1;
              next_st.pending = 1'b1;
            end
          end
          `PQSC_AV_TASK: begin
            next_st.feature_cur = avs_writedata[7:0] & 8'hC7;
            next_st.feature_prev = avs_writedata[15:8];
            next_st.count_cur = avs_writedata[23:16];
            next_st.count_prev = avs_writedata[31:24];
          end
          default: begin
          end
        endcase
      end else begin
        case (avs_address)
          `PQSC_AV_CTRL: next_st.rdata = {16'h0000, st.drive_head, st.command};
          `PQSC_AV_TASK: next_st.rdata = {st.count_prev, st.count_cur,
                                          st.feature_prev, st.feature_cur};
          `PQSC_AV_RESULT: next_st.rdata = {8'h00, st.count_in, st.error, st.status};
          `PQSC_AV_STAT: next_st.rdata = {31'h0000_0000, st.pending};
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Result captured with the device's interrupt
    if (link.done_irq) begin
      next_st.pending = 1'b0;
      next_st.status = link.command_status_flags;
      next_st.error = link.command_error_flags;
      next_st.count_in = link.count_out;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.cmd_valid = st.issue;
  assign link.command = st.command;
  assign link.drive_head = st.drive_head;
  assign link.feature_cur = st.feature_cur;
  assign link.feature_prev = st.feature_prev;
  assign link.count_cur = st.count_cur;
  assign link.count_prev = st.count_prev;
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
endmodule

// ===== verification/pqsc_asserts.sv
`timescale 1ns/1ps
// ****
// Link checker
// ****
module pqsc_link_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] command,
  input wire logic [7:0] feature_cur,
  input wire logic [7:0] drive_head,
  input wire logic done_irq,
  input wire logic [7:0] command_status_flags,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] count_out
);
  logic [7:0] seen;
  logic is_query;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  assign is_query = (command == 8'hE5) || (command == 8'h98);
  // Shadow of added streams, so a removal abort can be predicted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen <= 8'h00;
    end else if (done_irq && command == 8'h51 && !command_status_flags[0]) begin
      seen[feature_cur[2:0]] <= feature_cur[7];
    end
  end
  chk_done_pulse: assert property (cmd_valid |=> done_irq ##1 !done_irq)
    else $error("completion pulse missing or long");
  chk_no_stray: assert property (done_irq |-> $past(cmd_valid))
    else $error("completion without a command");
  chk_flags_hold: assert property (!done_irq |-> $stable(command_status_flags)
    && $stable(command_error_flags) && $stable(count_out)) else $error("flags moved early");
  chk_status_clean: assert property (done_irq |-> command_status_flags[7:5] == 3'h2
    && !command_status_flags[2]) else $error("busy, fault or corrected left set");
  chk_abort_only: assert property (done_irq |-> command_error_flags ==
    {5'h00, command_status_flags[0], 2'h0}) else $error("error bits wrong");
  chk_query_code: assert property (done_irq && is_query |->
    command_status_flags == 8'h50
    && count_out inside {8'hFF, 8'h00, 8'h81, 8'h82, 8'h83, 8'h01}) else $error("bad power code");
  chk_unknown_op: assert property (done_irq && !is_query && command != 8'h51 |->
    command_status_flags == 8'h41 && command_error_flags == 8'h04)
    else $error("opcode not aborted");
  chk_remove_fresh: assert property (done_irq && command == 8'h51 && !feature_cur[7]
    && !seen[feature_cur[2:0]] |-> command_status_flags[0]) else $error("bad removal accepted");
  chk_dh_reserved: assert property (cmd_valid |-> drive_head[7] == 1'b0
    && drive_head[4] == 1'b0 && feature_cur[5:3] == 3'h0) else $error("reserved bits set");
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk, resetn, avs_read, avs_write, stream_supported, ext_power_enable;
  logic avs_waitrequest, lba_mode;
  logic [1:0] avs_address;
  logic [2:0] query_id;
  logic [31:0] elapsed_cycles;
  logic [31:0] avs_writedata, avs_readdata, query_limit_us, applied_limit_us, rd, rng;
  logic [24:0] w_exp;
  logic [24:0] exp_q[$];
  pqsc_pkg::pqsc_pwr_t power_state;
  int n_errors, check_count;
  pqsc_if link();
  pqsc_host u_pqsc_host (.ref_clk(ref_clk), .resetn(resetn), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  pqsc_device #(.STREAMS(8), .TIME_UNIT_US(16'h000A), .MIN_LIMIT_US(32'h0000_0064))
    u_pqsc_device (
    .ref_clk(ref_clk), .resetn(resetn), .link(link), .stream_supported(stream_supported),
    .ext_power_enable(ext_power_enable), .power_state(power_state), .query_id(query_id),
    .query_limit_us(query_limit_us), .applied_limit_us(applied_limit_us),
    .lba_mode(lba_mode), .elapsed_cycles(elapsed_cycles));
  pqsc_link_asserts u_pqsc_link_asserts (.ref_clk(ref_clk), .resetn(resetn),
    .cmd_valid(link.cmd_valid), .command(link.command), .feature_cur(link.feature_cur),
    .drive_head(link.drive_head), .done_irq(link.done_irq),
    .command_status_flags(link.command_status_flags),
    .command_error_flags(link.command_error_flags), .count_out(link.count_out));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Idle sub-levels only show with extended conditions enabled
  function automatic logic [7:0] pcode(input logic ext, input logic [2:0] p);
    case (p)
      3'h1: return ext ? 8'h81 : 8'hFF;
      3'h2: return ext ? 8'h82 : 8'hFF;
      3'h3: return ext ? 8'h83 : 8'hFF;
      3'h4: return ext ? 8'h01 : 8'h00;
      3'h5: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Request stands from just after an edge until waitrequest is seen low at a rising edge
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] dh, input logic [31:0] tw,
      input logic [24:0] e);
    int n;
    av(1'b1, 2'h1, tw);
    exp_q.push_back(e);
    av(1'b1, 2'h0, {16'h0000, dh, op});
    rd = 32'h0000_0001;
    n = 0;
    while (rd[0] && n < 20) begin
      av(1'b0, 2'h3, 32'h0000_0000);
      n++;
    end
    cmp("pending", 32'h0000_0000, {31'h0, rd[0]});
    cmp("lba_mode", {31'h0, dh[6]}, {31'h0, lba_mode});
    cmp("elapsed_cycles", 32'h0000_0001, elapsed_cycles);
    if (rd[0]) begin
      complete_run();
    end
  endtask
  task automatic scfg(input logic sup, input logic [7:0] fc, input logic [7:0] prev,
      input logic ok);
    rng = xs(rng);
    @(posedge ref_clk);
    stream_supported <= sup;
    issue(8'h51, rng[7:0], {rng[31:16], prev, fc | {1'b0, rng[6:3], 3'h0}},
      {1'b0, 8'h00, ok ? 8'h04 ^ 8'h04 : 8'h04, ok ? 8'h50 : 8'h41});
  endtask
  task automatic chk_limit(input logic [2:0] id, input logic [31:0] lim, input logic [31:0] e);
    @(posedge ref_clk);
    query_id <= id;
    query_limit_us <= lim;
    repeat (3) @(posedge ref_clk);
    cmp("applied_limit_us", e, applied_limit_us);
  endtask
  // Watcher: each completion takes the oldest note
  always @(posedge ref_clk) begin
    if (link.done_irq === 1'b1) begin
      w_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FF_FFFF;
      cmp("status", {24'h0, w_exp[7:0]}, {24'h0, link.command_status_flags});
      cmp("error", {24'h0, w_exp[15:8]}, {24'h0, link.command_error_flags});
      if (w_exp[24]) cmp("count_out", {24'h0, w_exp[23:16]}, {24'h0, link.count_out});
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {resetn, avs_read, avs_write, stream_supported, ext_power_enable} = 5'h00;
    {avs_address, avs_writedata, query_id, query_limit_us} = '0;
    power_state = pqsc_pkg::PQSC_PWR_ACTIVE;
    rng = 32'h0000_005A;
    n_errors = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // Every power state, both opcodes, extended conditions off then on
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      @(posedge ref_clk);
      ext_power_enable <= (i >= 6);
      power_state <= pqsc_pkg::pqsc_pwr_t'(3'(i % 6));
      issue(i[0] ? 8'h98 : 8'hE5, rng[7:0], rng, {1'b1, pcode(i >= 6, 3'(i % 6)), 16'h0050});
    end
    scfg(1'b0, 8'h82, 8'h1E, 1'b0);
    scfg(1'b1, 8'h05, 8'h00, 1'b0);
    scfg(1'b1, 8'h83, 8'h05, 1'b1);
    chk_limit(3'h3, 32'h0000_0000, 32'h0000_0064);
    chk_limit(3'h3, 32'h0000_004D, 32'h0000_004D);
    scfg(1'b1, 8'h83, 8'h14, 1'b1);
    chk_limit(3'h3, 32'h0000_0000, 32'h0000_00C8);
    scfg(1'b0, 8'h83, 8'h1E, 1'b0);
    chk_limit(3'h3, 32'h0000_0000, 32'h0000_00C8);
    scfg(1'b1, 8'h03, 8'h00, 1'b1);
    chk_limit(3'h3, 32'h0000_0000, 32'h0000_0000);
    issue(8'hEC, 8'h40, 32'h0000_0000, 25'h000_0441);
    av(1'b0, 2'h2, 32'h0000_0000);
    cmp("result", 32'h0000_0441, {16'h0000, rd[15:0]});
    cmp("notes_left", 32'h0000_0000, 32'(exp_q.size()));
    complete_run();
  end
endmodule
